// ---- inc/config_loader_map.svh ----
// Offsets, field positions, reset values and timing for the configuration loader
`ifndef CONFIG_LOADER_MAP_SVH
`define CONFIG_LOADER_MAP_SVH

`define CBL_BYTE_ZERO        2'h0
`define CBL_BYTE_ONE         2'h1
`define CBL_BYTE_TWO         2'h2
`define CBL_BYTE_THREE       2'h3
`define CBL_ERASED           8'hFF

`define CBL_B0_BOOT          7
`define CBL_B0_DF_EN_N       0
`define CBL_B2_BOD_EN        7
`define CBL_B2_BOD_LVL       6
`define CBL_B2_BOD_RST       4
`define CBL_B3_WDT_OFF       7
`define CBL_B3_CLK_FILT      4
`define CBL_B3_RC_RATE       3
`define CBL_B3_SRC_HI        1
`define CBL_B3_SRC_LO        0

`define CBL_LIVE_BOOT        3'h0
`define CBL_LIVE_DF          3'h1
`define CBL_LIVE_BASE        3'h2
`define CBL_LIVE_BOD         3'h3
`define CBL_LIVE_WDT         3'h4
`define CBL_LIVE_CLK         3'h5

`define CBL_MIN_PROG_BYTES   16'h0100
`define CBL_BASE_ZERO        8'h00
`define CBL_CLK_PERIOD_PS    5000
`define CBL_HOLD_NS          100

`endif

// ---- inc/config_loader_pkg.sv ----
// Types shared by the configuration loader modules
package config_loader_pkg;

	typedef enum logic [1:0] {
		S_LOAD_ALL = 2'b00,
		S_LOAD_SW  = 2'b01,
		S_HOLD     = 2'b10,
		S_RUN      = 2'b11
	} seq_state_t;

	typedef enum logic [1:0] {
		SRC_RC      = 2'b00,
		SRC_EXT_OSC = 2'b01,
		SRC_XTAL    = 2'b10
	} clk_src_t;

endpackage

// ---- core/nv_config_store.sv ----
// Non-volatile store of the four configuration bytes
`timescale 1ns/1ps
`include "config_loader_map.svh"

module nv_config_store (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Programming session
	input  wire logic       prog_en,
	input  wire logic       prog_we,
	input  wire logic       prog_erase,
	input  wire logic [1:0] prog_sel,
	input  wire logic [7:0] prog_wdata,
	output logic      [7:0] prog_rdata,
	// Stored bytes
	output logic      [7:0] byte_zero,
	output logic      [7:0] byte_one,
	output logic      [7:0] byte_two,
	output logic      [7:0] byte_three
);

	// Erased cells at manufacture; a chip reset must not disturb them
	logic [7:0] mem [0:3] = '{default: `CBL_ERASED};

	always_ff @(posedge clk) begin
		if (prog_en && prog_erase) begin
			for (int i = 0; i < 4; i++) begin
				mem[i] <= `CBL_ERASED;
			end
		end else if (prog_en && prog_we) begin
			// Flash cells only clear on program
			mem[prog_sel] <= mem[prog_sel] & prog_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_rdata <= `CBL_ERASED;
		end else begin
			prog_rdata <= mem[prog_sel];
		end
	end

	assign byte_zero  = mem[`CBL_BYTE_ZERO];
	assign byte_one   = mem[`CBL_BYTE_ONE];
	assign byte_two   = mem[`CBL_BYTE_TWO];
	assign byte_three = mem[`CBL_BYTE_THREE];

	property p_erase_ones;
		@(posedge clk) disable iff (!rst_n)
		prog_en && prog_erase |=> byte_zero == `CBL_ERASED && byte_three == `CBL_ERASED;
	endproperty
	a_erase_ones: assert property (p_erase_ones) else $error("erase did not leave ones");

endmodule

// ---- core/load_sequencer.sv ----
// Reset sequencer: issues the copy and then releases the processor
`timescale 1ns/1ps
`include "config_loader_map.svh"

module load_sequencer (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Reset sources
	input  wire logic hw_reset_req,
	input  wire logic sw_reset_req,
	// Control
	output logic      load_all,
	output logic      load_sw,
	output logic      cpu_reset_n
);

	localparam int HOLD_CYC = (`CBL_HOLD_NS * 1000 + `CBL_CLK_PERIOD_PS - 1) / `CBL_CLK_PERIOD_PS;

	config_loader_pkg::seq_state_t state_r;
	config_loader_pkg::seq_state_t state_nxt;
	logic [4:0]                    cnt_r;
	wire                           hold_done = (cnt_r == 5'(HOLD_CYC - 1));

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			config_loader_pkg::S_LOAD_ALL: state_nxt = config_loader_pkg::S_HOLD;
			config_loader_pkg::S_LOAD_SW:  state_nxt = config_loader_pkg::S_HOLD;
			config_loader_pkg::S_HOLD: begin
				if (hold_done) begin
					state_nxt = config_loader_pkg::S_RUN;
				end
			end
			config_loader_pkg::S_RUN: begin
				if (sw_reset_req) begin
					state_nxt = config_loader_pkg::S_LOAD_SW;
				end
			end
			default: state_nxt = config_loader_pkg::S_LOAD_ALL;
		endcase
		// A full reset outranks everything, even mid-hold
		if (hw_reset_req) begin
			state_nxt = config_loader_pkg::S_LOAD_ALL;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= config_loader_pkg::S_LOAD_ALL;
			cnt_r   <= 5'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= (state_r == config_loader_pkg::S_HOLD) ? cnt_r + 5'h01 : 5'h00;
		end
	end

	assign load_all = (state_r == config_loader_pkg::S_LOAD_ALL);
	assign load_sw  = (state_r == config_loader_pkg::S_LOAD_SW);
	assign cpu_reset_n = (state_r == config_loader_pkg::S_RUN);

endmodule

// ---- core/config_byte_reset_loader.sv ----
// Configuration byte store and reset-time loader of the live option bits
`timescale 1ns/1ps
`include "config_loader_map.svh"

module config_byte_reset_loader (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Reset sources
	input  wire logic       hw_reset_pin,
	input  wire logic       sw_reset_req,
	// Programmer pins
	input  wire logic       prog_en_pin,
	input  wire logic       prog_we_pin,
	input  wire logic       prog_erase_pin,
	input  wire logic [1:0] prog_sel_pin,
	input  wire logic [7:0] prog_wdata_pin,
	output logic      [7:0] prog_rdata,
	// Live register write and read
	input  wire logic       live_wr_en,
	input  wire logic [2:0] live_sel,
	input  wire logic [7:0] live_wr_data,
	output logic      [7:0] live_rd_data,
	// Processor control
	output logic            cpu_reset_n,
	output logic            boot_from_loader,
	// Data flash and memory
	output logic            data_flash_enable_n,
	output logic      [7:0] data_flash_base_high,
	output logic            app_area_absent,
	output logic     [15:0] prog_mem_limit,
	// Brown-out
	output logic            brownout_detect_enable,
	output logic            brownout_level_select,
	output logic            brownout_reset_enable,
	// Watchdog and clock
	output logic            watchdog_run_enable,
	output logic            clock_filter_enable,
	output logic            rc_rate_select,
	output logic      [1:0] clock_source
);

	// Pin synchronisers; first stage read only by the second
	logic [12:0] pin_s1_r;
	logic [12:0] pin_s2_r;
	logic [1:0]  strobe_d_r;
	logic        hw_s1_r;
	logic        hw_s2_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r   <= 13'h0000;
			pin_s2_r   <= 13'h0000;
			strobe_d_r <= 2'h0;
			hw_s1_r    <= 1'b0;
			hw_s2_r    <= 1'b0;
		end else begin
			pin_s1_r   <= {prog_en_pin, prog_we_pin, prog_erase_pin, prog_sel_pin, prog_wdata_pin};
			pin_s2_r   <= pin_s1_r;
			strobe_d_r <= pin_s2_r[11:10];
			hw_s1_r    <= hw_reset_pin;
			hw_s2_r    <= hw_s1_r;
		end
	end

	// Edge detect so one held strobe programs once
	wire       prog_en_s  = pin_s2_r[12];
	wire       prog_we_p  = pin_s2_r[11] & ~strobe_d_r[1];
	wire       prog_er_p  = pin_s2_r[10] & ~strobe_d_r[0];
	wire [1:0] prog_sel_s = pin_s2_r[9:8];
	wire [7:0] prog_dat_s = pin_s2_r[7:0];

	logic [7:0] cfg0;
	logic [7:0] cfg1;
	logic [7:0] cfg2;
	logic [7:0] cfg3;

	nv_config_store u_store (
		.clk        (clk),
		.rst_n      (rst_n),
		.prog_en    (prog_en_s),
		.prog_we    (prog_we_p),
		.prog_erase (prog_er_p),
		.prog_sel   (prog_sel_s),
		.prog_wdata (prog_dat_s),
		.prog_rdata (prog_rdata),
		.byte_zero  (cfg0),
		.byte_one   (cfg1),
		.byte_two   (cfg2),
		.byte_three (cfg3)
	);

	logic load_all;
	logic load_sw;

	load_sequencer u_seq (
		.clk          (clk),
		.rst_n        (rst_n),
		.hw_reset_req (hw_s2_r),
		.sw_reset_req (sw_reset_req),
		.load_all     (load_all),
		.load_sw      (load_sw),
		.cpu_reset_n  (cpu_reset_n)
	);

	wire load_any = load_all | load_sw;
	// Software may only touch live bits while the processor runs
	wire sw_wr    = live_wr_en & cpu_reset_n;
	wire wr_boot  = sw_wr & (live_sel == `CBL_LIVE_BOOT);
	wire wr_df    = sw_wr & (live_sel == `CBL_LIVE_DF);
	wire wr_base  = sw_wr & (live_sel == `CBL_LIVE_BASE);
	wire wr_bod   = sw_wr & (live_sel == `CBL_LIVE_BOD);
	wire wr_wdt   = sw_wr & (live_sel == `CBL_LIVE_WDT);
	wire wr_clk   = sw_wr & (live_sel == `CBL_LIVE_CLK);

	logic       live_boot_select_r;
	logic       df_en_n_r;
	logic [7:0] df_base_r;
	logic [2:0] bod_r;
	logic       wdt_run_r;
	logic [3:0] clk_cfg_r;
	logic       boot_area_r;

	// Values before the first copy equal erased bytes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			live_boot_select_r <= 1'b0;
			df_en_n_r          <= 1'b1;
			df_base_r          <= `CBL_ERASED;
			bod_r              <= 3'h7;
			wdt_run_r          <= 1'b0;
			clk_cfg_r          <= 4'hF;
		end else if (load_any) begin
			if (load_all) begin
				live_boot_select_r <= ~cfg0[`CBL_B0_BOOT];
			end
			df_en_n_r <= cfg0[`CBL_B0_DF_EN_N];
			df_base_r <= cfg1;
			bod_r     <= {cfg2[`CBL_B2_BOD_EN], cfg2[`CBL_B2_BOD_LVL], cfg2[`CBL_B2_BOD_RST]};
			wdt_run_r <= ~cfg3[`CBL_B3_WDT_OFF];
			clk_cfg_r <= {cfg3[`CBL_B3_CLK_FILT], cfg3[`CBL_B3_RC_RATE],
				cfg3[`CBL_B3_SRC_HI], cfg3[`CBL_B3_SRC_LO]};
		end else begin
			if (wr_boot) begin
				live_boot_select_r <= live_wr_data[0];
			end
			if (wr_df) begin
				df_en_n_r <= live_wr_data[0];
			end
			if (wr_base) begin
				df_base_r <= live_wr_data;
			end
			if (wr_bod) begin
				bod_r <= live_wr_data[2:0];
			end
			if (wr_wdt) begin
				wdt_run_r <= live_wr_data[0];
			end
			if (wr_clk) begin
				clk_cfg_r <= live_wr_data[3:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_area_r <= 1'b0;
		end else if (!cpu_reset_n) begin
			boot_area_r <= live_boot_select_r;
		end
	end

	assign boot_from_loader = boot_area_r;

	wire df_valid = ~df_en_n_r;
	assign data_flash_enable_n  = df_en_n_r;
	assign data_flash_base_high = df_base_r;

	assign app_area_absent = df_valid && (df_base_r == `CBL_BASE_ZERO);
	assign prog_mem_limit  = app_area_absent ? `CBL_MIN_PROG_BYTES : {df_base_r, 8'h00};

	assign brownout_detect_enable = bod_r[2];
	assign brownout_level_select = bod_r[1];
	assign brownout_reset_enable = bod_r[0];

	assign watchdog_run_enable = wdt_run_r;
	assign clock_filter_enable = clk_cfg_r[3];
	assign rc_rate_select = clk_cfg_r[2];

	function automatic config_loader_pkg::clk_src_t src_decode(input logic [1:0] sel);
		if (!sel[1]) begin
			return config_loader_pkg::SRC_XTAL;
		end
		return sel[0] ? config_loader_pkg::SRC_RC : config_loader_pkg::SRC_EXT_OSC;
	endfunction

	assign clock_source = src_decode(clk_cfg_r[1:0]);

	wire [7:0] rd_mux =
		(live_sel == `CBL_LIVE_BOOT) ? {7'h00, live_boot_select_r} :
		(live_sel == `CBL_LIVE_DF)   ? {7'h00, df_en_n_r} :
		(live_sel == `CBL_LIVE_BASE) ? df_base_r :
		(live_sel == `CBL_LIVE_BOD)  ? {5'h00, bod_r} :
		(live_sel == `CBL_LIVE_WDT)  ? {7'h00, wdt_run_r} :
		(live_sel == `CBL_LIVE_CLK)  ? {4'h0, clk_cfg_r} : 8'h00;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			live_rd_data <= 8'h00;
		end else begin
			live_rd_data <= rd_mux;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_copy;
		load_any ##1 !cpu_reset_n;
	endsequence

	sequence s_held;
		!cpu_reset_n [*8];
	endsequence

	property p_boot_full;
		load_all |=> live_boot_select_r == ~$past(cfg0[`CBL_B0_BOOT]);
	endproperty
	a_boot_full: assert property (p_boot_full) else $error("boot bit not inverse of field");

	property p_boot_keep;
		load_sw |=> live_boot_select_r == $past(live_boot_select_r);
	endproperty
	a_boot_keep: assert property (p_boot_keep) else $error("software reset changed boot bit");

	property p_wdt_inv;
		load_any |=> watchdog_run_enable == ~$past(cfg3[`CBL_B3_WDT_OFF]);
	endproperty
	a_wdt_inv: assert property (p_wdt_inv) else $error("watchdog not inverse of field");

	property p_copy_base;
		load_any |=> data_flash_base_high == $past(cfg1) && data_flash_enable_n == $past(cfg0[`CBL_B0_DF_EN_N]);
	endproperty
	a_copy_base: assert property (p_copy_base) else $error("data flash fields not copied");

	property p_hold_cpu;
		s_copy |-> s_held;
	endproperty
	a_hold_cpu: assert property (p_hold_cpu) else $error("processor released too early");

	property p_boot_area;
		$rose(cpu_reset_n) |-> boot_from_loader == live_boot_select_r;
	endproperty
	a_boot_area: assert property (p_boot_area) else $error("boot area not from live bit");

	property p_live_wr;
		wr_base && !load_any |=> data_flash_base_high == $past(live_wr_data);
	endproperty
	a_live_wr: assert property (p_live_wr) else $error("live base write lost");

	property p_no_app;
		df_valid && df_base_r == `CBL_BASE_ZERO |-> app_area_absent && prog_mem_limit == `CBL_MIN_PROG_BYTES;
	endproperty
	a_no_app: assert property (p_no_app) else $error("minimum program memory not selected");

	property p_src;
		!clk_cfg_r[1] |-> clock_source == config_loader_pkg::SRC_XTAL;
	endproperty
	a_src: assert property (p_src) else $error("crystal not selected");

endmodule

// ---- testbench/nv_programmer_model.sv ----
// Programmer model that erases, writes and reads the configuration store
`timescale 1ns/1ps

module nv_programmer_model (
	// Clock
	input  wire logic       clk,
	// Programmer pins
	output logic            prog_en_pin,
	output logic            prog_we_pin,
	output logic            prog_erase_pin,
	output logic      [1:0] prog_sel_pin,
	output logic      [7:0] prog_wdata_pin,
	input  wire logic [7:0] prog_rdata
);
	initial begin
		prog_en_pin    = 1'b0;
		prog_we_pin    = 1'b0;
		prog_erase_pin = 1'b0;
		prog_sel_pin   = 2'h0;
		prog_wdata_pin = 8'h00;
	end

	function automatic logic [7:0] keep_mask(input logic [1:0] s);
		case (s)
			2'h0: keep_mask = 8'h7E;
			2'h2: keep_mask = 8'h2F;
			2'h3: keep_mask = 8'h64;
			default: keep_mask = 8'h00;
		endcase
	endfunction

	task automatic strobe(input logic erase, input logic [1:0] s, input logic [7:0] d);
		prog_sel_pin   = s;
		prog_wdata_pin = d | keep_mask(s);
		prog_en_pin    = 1'b1;
		repeat (3) @(negedge clk);
		prog_erase_pin = erase;
		prog_we_pin    = !erase;
		// Strobe levels held longer than the synchroniser needs
		repeat (4) @(negedge clk);
		prog_we_pin    = 1'b0;
		prog_erase_pin = 1'b0;
		repeat (4) @(negedge clk);
		prog_en_pin    = 1'b0;
		// Released lines show junk, not the last value
		prog_sel_pin   = ~s;
		prog_wdata_pin = ~prog_wdata_pin;
		@(negedge clk);
	endtask

	task automatic read_byte(input logic [1:0] s, output logic [7:0] d);
		prog_sel_pin = s;
		repeat (5) @(negedge clk);
		d = prog_rdata;
	endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench of the configuration byte loader
`timescale 1ns/1ps

`define CHK(what, exp, got) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) begin \
			errors++; \
			$display("unexpected %s: expected %0h seen %0h", what, exp, got); \
		end \
	end

module tb;
	logic        clk;
	logic        rst_n;
	logic        hw_reset_pin;
	logic        sw_reset_req;
	logic        live_wr_en;
	logic [2:0]  live_sel;
	logic [7:0]  live_wr_data;
	wire         prog_en_pin;
	wire         prog_we_pin;
	wire         prog_erase_pin;
	wire  [1:0]  prog_sel_pin;
	wire  [7:0]  prog_wdata_pin;
	wire  [7:0]  prog_rdata;
	wire  [7:0]  live_rd_data;
	wire         cpu_reset_n;
	wire         boot_from_loader;
	wire         data_flash_enable_n;
	wire  [7:0]  data_flash_base_high;
	wire         app_area_absent;
	wire  [15:0] prog_mem_limit;
	wire         brownout_detect_enable;
	wire         brownout_level_select;
	wire         brownout_reset_enable;
	wire         watchdog_run_enable;
	wire         clock_filter_enable;
	wire         rc_rate_select;
	wire  [1:0]  clock_source;
	int          errors;
	int          n_tests;
	int          cnt;
	logic [31:0] seed;
	logic [31:0] r;
	logic [7:0]  nv [4];
	logic [7:0]  d;
	logic        lb;

	config_byte_reset_loader config_byte_reset_loader_i (
		.clk(clk), .rst_n(rst_n), .hw_reset_pin(hw_reset_pin), .sw_reset_req(sw_reset_req),
		.prog_en_pin(prog_en_pin), .prog_we_pin(prog_we_pin), .prog_erase_pin(prog_erase_pin),
		.prog_sel_pin(prog_sel_pin), .prog_wdata_pin(prog_wdata_pin), .prog_rdata(prog_rdata),
		.live_wr_en(live_wr_en), .live_sel(live_sel), .live_wr_data(live_wr_data),
		.live_rd_data(live_rd_data), .cpu_reset_n(cpu_reset_n), .boot_from_loader(boot_from_loader),
		.data_flash_enable_n(data_flash_enable_n), .data_flash_base_high(data_flash_base_high),
		.app_area_absent(app_area_absent), .prog_mem_limit(prog_mem_limit),
		.brownout_detect_enable(brownout_detect_enable), .brownout_level_select(brownout_level_select),
		.brownout_reset_enable(brownout_reset_enable), .watchdog_run_enable(watchdog_run_enable),
		.clock_filter_enable(clock_filter_enable), .rc_rate_select(rc_rate_select),
		.clock_source(clock_source)
	);

	nv_programmer_model nv_programmer_model_i (
		.clk(clk), .prog_en_pin(prog_en_pin), .prog_we_pin(prog_we_pin),
		.prog_erase_pin(prog_erase_pin), .prog_sel_pin(prog_sel_pin),
		.prog_wdata_pin(prog_wdata_pin), .prog_rdata(prog_rdata)
	);

	always #2.5 clk = ~clk;

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [1:0] exp_src(input logic [7:0] b3);
		if (!b3[1])
			return 2'h2;
		return b3[0] ? 2'h0 : 2'h1;
	endfunction

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check_all(input logic [7:0] b0, b1, b2, b3, input logic boot);
		logic absent;
		absent = !b0[0] && (b1 == 8'h00);
		`CHK("boot", boot, boot_from_loader)
		`CHK("df_en_n", b0[0], data_flash_enable_n)
		`CHK("base", b1, data_flash_base_high)
		`CHK("absent", absent, app_area_absent)
		`CHK("limit", absent ? 16'h0100 : {b1, 8'h00}, prog_mem_limit)
		`CHK("bod_en", b2[7], brownout_detect_enable)
		`CHK("bod_lvl", b2[6], brownout_level_select)
		`CHK("bod_rst", b2[4], brownout_reset_enable)
		`CHK("wd_run", ~b3[7], watchdog_run_enable)
		`CHK("filter", b3[4], clock_filter_enable)
		`CHK("rate", b3[3], rc_rate_select)
		`CHK("src", exp_src(b3), clock_source)
	endtask

	// Bounded wait for the processor to be held and then let go
	task automatic wait_release(input logic fall, output int low_cnt);
		int k;
		k = 0;
		low_cnt = 0;
		while (fall && cpu_reset_n !== 1'b0 && k < 10) begin
			@(negedge clk);
			k++;
		end
		while (cpu_reset_n !== 1'b1 && low_cnt < 100) begin
			@(negedge clk);
			low_cnt++;
		end
		if (k == 10 || low_cnt == 100) begin
			errors++;
			$display("unexpected cpu_reset_n: expected release seen timeout");
			give_verdict();
		end
	endtask

	task automatic live_write(input logic [2:0] s, input logic [7:0] v);
		live_sel     = s;
		live_wr_data = v;
		live_wr_en   = 1'b1;
		@(negedge clk);
		live_wr_en   = 1'b0;
		@(negedge clk);
	endtask

	task automatic live_read(input logic [2:0] s, output logic [7:0] v);
		live_sel = s;
		@(negedge clk);
		v = live_rd_data;
	endtask

	// Random bytes with corners: no application area, then zero base but disabled
	task automatic new_bytes(input int i);
		r     = xs();
		nv[0] = r[7:0] | 8'h7E;
		nv[1] = r[15:8];
		nv[2] = r[23:16] | 8'h2F;
		nv[3] = {r[31:26], i[1:0]} | 8'h64;
		if (i < 2) begin
			nv[0][0] = i[0];
			nv[1]    = 8'h00;
		end
	endtask

	task automatic program_all();
		logic [7:0] v;
		nv_programmer_model_i.strobe(1'b1, 2'h0, 8'hFF);
		nv_programmer_model_i.read_byte(2'h3, v);
		`CHK("erased", 8'hFF, v)
		for (int s = 0; s < 4; s++) begin
			nv_programmer_model_i.strobe(1'b0, s[1:0], nv[s]);
			nv_programmer_model_i.read_byte(s[1:0], v);
			`CHK("stored", nv[s], v)
		end
	endtask

	initial begin
		clk          = 1'b0;
		rst_n        = 1'b0;
		hw_reset_pin = 1'b0;
		sw_reset_req = 1'b0;
		live_wr_en   = 1'b0;
		live_sel     = 3'h0;
		live_wr_data = 8'h00;
		errors       = 0;
		n_tests      = 0;
		seed         = 32'd81;
		repeat (3) @(negedge clk);
		check_all(8'hFF, 8'hFF, 8'hFF, 8'hFF, 1'b0);
		`CHK("cpu_held", 1'b0, cpu_reset_n)
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		wait_release(1'b0, cnt);
		`CHK("por_hold", 21, cnt)
		check_all(8'hFF, 8'hFF, 8'hFF, 8'hFF, 1'b0);
		for (int i = 0; i < 6; i++) begin
			new_bytes(i);
			program_all();
			hw_reset_pin = 1'b1;
			repeat (4) @(negedge clk);
			hw_reset_pin = 1'b0;
			wait_release(1'b1, cnt);
			check_all(nv[0], nv[1], nv[2], nv[3], ~nv[0][7]);
			r  = xs();
			lb = r[0];
			live_write(3'h0, {7'h00, lb});
			live_write(3'h2, r[15:8]);
			live_read(3'h2, d);
			`CHK("live_base_rd", r[15:8], d)
			`CHK("live_base", r[15:8], data_flash_base_high)
			live_read(3'h7, d);
			`CHK("unmapped_rd", 8'h00, d)
			new_bytes(i + 1);
			program_all();
			sw_reset_req = 1'b1;
			@(negedge clk);
			sw_reset_req = 1'b0;
			wait_release(1'b1, cnt);
			`CHK("sw_hold", 21, cnt)
			check_all(nv[0], nv[1], nv[2], nv[3], lb);
		end
		give_verdict();
	end
endmodule
